// *** core/work_bit_pkg.sv ***
// Purpose: Shared constants for the work bit logic evaluator.
// Assumes: Control clock of 10 MHz, one evaluation per control cycle strobe.
// Notes: Source codes index the selectable input table of every work bit.

package work_bit_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_WORK_BITS = 8;
    localparam int NUM_INPUTS = 4;
    localparam int NUM_EVENTS = 6;
    localparam int CODE_W = 6;
    localparam int OP_W = 3;
    localparam int DELAY_W = 14;
    localparam int NUM_SOURCES = 47;

    // ------------------------------------------------------------------
    // Operation types
    // ------------------------------------------------------------------
    localparam logic [OP_W-1:0] OP_NONE = 3'h0;
    localparam logic [OP_W-1:0] OP_AB_OR_CD = 3'h1;
    localparam logic [OP_W-1:0] OP_AC_AND_BD = 3'h2;
    localparam logic [OP_W-1:0] OP_ANY = 3'h3;
    localparam logic [OP_W-1:0] OP_ALL = 3'h4;

    // ------------------------------------------------------------------
    // Source code positions
    // ------------------------------------------------------------------
    localparam int SRC_OFF = 0;
    localparam int SRC_ON = 1;
    localparam int SRC_POWER_UP = 2;
    localparam int SRC_EVENT = 3;
    localparam int SRC_ALARM = 9;
    localparam int SRC_HEAT = 13;
    localparam int SRC_COOL = 14;
    localparam int SRC_INPUT_ERROR = 15;
    localparam int SRC_HEATER_BURNOUT = 16;
    localparam int SRC_SSR_SHORT = 17;
    localparam int SRC_STATUS = 18;
    localparam int SRC_TIME_SIGNAL = 26;
    localparam int SRC_PROGRAM_END = 28;
    localparam int SRC_STAGE = 29;
    localparam int SRC_PROGRAM_NUM = 30;
    localparam int SRC_RESERVED = 33;
    localparam int SRC_SEGMENT = 34;
    localparam int SRC_WORK_BIT = 39;

    // ------------------------------------------------------------------
    // Timing and reset values
    // ------------------------------------------------------------------
    localparam int CLOCK_HZ = 10_000_000;
    localparam int SECOND_S = 1;
    localparam int CYCLES_PER_SECOND = CLOCK_HZ * SECOND_S;
    localparam int SECONDS_PER_MINUTE = 60;
    localparam logic [DELAY_W-1:0] DELAY_MAX = 14'h270f;
    localparam logic [DELAY_W-1:0] DELAY_RESET = 14'h0000;

endpackage

// *** core/work_bit_logic_evaluator.sv ***
// Purpose: Eight configurable work bits with selectable inputs and delays.
// Assumes: cycle_tick pulses once per control cycle in the clk domain;
//          event inputs arrive from pins, all other status from logic.
// Notes: Delay settings above the range maximum are clamped.

`timescale 1ns/10ps

module work_bit_logic_evaluator
    import work_bit_pkg::*;
#(
    parameter int CYCLES_PER_SEC = CYCLES_PER_SECOND,
    parameter int N = NUM_WORK_BITS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control cycle strobe
    input wire logic cycle_tick,
    // Configuration, one field per work bit except the shared delay_in_minutes
    input wire logic [N*OP_W-1:0] op_type,
    input wire logic [N*NUM_INPUTS*CODE_W-1:0] input_select,
    input wire logic [N*NUM_INPUTS-1:0] input_inverted,
    input wire logic [N-1:0] output_inverted,
    input wire logic [N*DELAY_W-1:0] on_delay,
    input wire logic [N*DELAY_W-1:0] off_delay,
    input wire logic delay_in_minutes,
    // External event pins
    input wire logic [NUM_EVENTS-1:0] event_in,
    // Controller status
    input wire logic [3:0] alarm,
    input wire logic heat_output,
    input wire logic cool_output,
    input wire logic input_error,
    input wire logic heater_burnout_alarm,
    input wire logic ssr_short_alarm,
    input wire logic auto_manual,
    input wire logic run_reset,
    input wire logic hold,
    input wire logic program_or_fixed_setpoint,
    input wire logic autotune,
    input wire logic ramp,
    input wire logic standby,
    input wire logic wait_state,
    input wire logic [1:0] time_signal,
    input wire logic program_end,
    input wire logic stage,
    input wire logic [2:0] program_number,
    input wire logic [4:0] segment_number,
    // Results
    output logic [N-1:0] work_bit
);

    // Time base widths follow the clock rate parameter
    localparam int PRE_W = $clog2(CYCLES_PER_SEC + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYCLES_PER_SEC - 1);
    localparam logic [5:0] MIN_LAST = 6'(SECONDS_PER_MINUTE - 1);

    // ------------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------------
    // Codes past the table read false, so a bad setting cannot turn on
    function automatic logic pick(input logic [NUM_SOURCES-1:0] src,
                                  input logic [CODE_W-1:0] code);
        logic res;
        res = 1'b0;
        if (code < CODE_W'(NUM_SOURCES)) begin
            res = src[code];
        end
        return res;
    endfunction

    // Unused and out-of-range types both read as no-operation
    function automatic logic op_is_off(input logic [OP_W-1:0] code);
        return (code == OP_NONE) || (code > OP_ALL);
    endfunction

    // ------------------------------------------------------------------
    // Event pin synchronisers
    // ------------------------------------------------------------------
    // Two stages, since the event pins are not timed to clk
    logic [NUM_EVENTS-1:0] event_meta;
    logic [NUM_EVENTS-1:0] event_sync;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            event_meta <= '0;
            event_sync <= '0;
        end else begin
            event_meta <= event_in;
            event_sync <= event_meta;
        end
    end

    // ------------------------------------------------------------------
    // Power-up pulse
    // ------------------------------------------------------------------
    logic first_cycle;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            first_cycle <= 1'b1;
        end else if (cycle_tick) begin
            first_cycle <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Delay time base
    // ------------------------------------------------------------------
    logic [PRE_W-1:0] prescale;
    logic [5:0] seconds;
    logic unit_pending;
    logic unit_tick;
    logic second_tick;

    // Free-running, so a delay may start anywhere within a unit
    assign second_tick = (prescale == PRE_LAST);
    assign unit_tick = second_tick &&
        (!delay_in_minutes || seconds == MIN_LAST);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prescale <= '0;
        end else if (second_tick) begin
            prescale <= '0;
        end else begin
            prescale <= prescale + 1'b1;
        end
    end

    // Minute phase follows this free-running seconds count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seconds <= '0;
        end else if (second_tick) begin
            seconds <= (seconds == MIN_LAST) ? 6'h00 : seconds + 6'h01;
        end
    end

    // Unit ticks wait for the next evaluation; a new tick wins over clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            unit_pending <= 1'b0;
        end else if (unit_tick) begin
            unit_pending <= 1'b1;
        end else if (cycle_tick) begin
            unit_pending <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Source table
    // ------------------------------------------------------------------
    logic [NUM_SOURCES-1:0] src;

    always_comb begin
        src = '0;
        src[SRC_OFF] = 1'b0;
        src[SRC_ON] = 1'b1;
        src[SRC_POWER_UP] = first_cycle;
        src[SRC_EVENT +: NUM_EVENTS] = event_sync;
        src[SRC_ALARM +: 4] = alarm;
        src[SRC_HEAT] = heat_output;
        src[SRC_COOL] = cool_output;
        src[SRC_INPUT_ERROR] = input_error;
        src[SRC_HEATER_BURNOUT] = heater_burnout_alarm;
        src[SRC_SSR_SHORT] = ssr_short_alarm;
        src[SRC_STATUS + 0] = auto_manual;
        src[SRC_STATUS + 1] = run_reset;
        src[SRC_STATUS + 2] = hold;
        src[SRC_STATUS + 3] = program_or_fixed_setpoint;
        src[SRC_STATUS + 4] = autotune;
        src[SRC_STATUS + 5] = ramp;
        src[SRC_STATUS + 6] = standby;
        src[SRC_STATUS + 7] = wait_state;
        src[SRC_TIME_SIGNAL +: 2] = time_signal;
        src[SRC_PROGRAM_END] = program_end;
        src[SRC_STAGE] = stage;
        src[SRC_PROGRAM_NUM +: 3] = program_number;
        src[SRC_RESERVED] = 1'b0;
        src[SRC_SEGMENT +: 5] = segment_number;
        // Registered values give each work bit last cycle's neighbours
        src[SRC_WORK_BIT +: NUM_WORK_BITS] = NUM_WORK_BITS'(work_bit);
    end

    // ------------------------------------------------------------------
    // Per work bit logic and delays
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_bit
            logic [NUM_INPUTS-1:0] in_val;
            logic [OP_W-1:0] op;
            logic combined;
            logic result;
            logic [DELAY_W-1:0] on_set;
            logic [DELAY_W-1:0] off_set;
            logic [DELAY_W-1:0] delay_set;
            logic [DELAY_W-1:0] count;
            logic op_off;
            logic flip;

            assign op = op_type[g*OP_W +: OP_W];
            assign op_off = op_is_off(op);
            // Settings past the top of the range clamp to it
            assign on_set = (on_delay[g*DELAY_W +: DELAY_W] > DELAY_MAX) ?
                DELAY_MAX : on_delay[g*DELAY_W +: DELAY_W];
            assign off_set = (off_delay[g*DELAY_W +: DELAY_W] > DELAY_MAX) ?
                DELAY_MAX : off_delay[g*DELAY_W +: DELAY_W];

            genvar k;
            for (k = 0; k < NUM_INPUTS; k++) begin : g_in
                assign in_val[k] = pick(src,
                    input_select[(g*NUM_INPUTS+k)*CODE_W +: CODE_W])
                    ^ input_inverted[g*NUM_INPUTS+k];
            end

            always_comb begin
                case (op)
                    OP_AB_OR_CD: begin
                        combined = (in_val[0] & in_val[1]) |
                                   (in_val[2] & in_val[3]);
                    end
                    OP_AC_AND_BD: begin
                        combined = (in_val[0] | in_val[2]) &
                                   (in_val[1] | in_val[3]);
                    end
                    OP_ANY: begin
                        combined = |in_val;
                    end
                    OP_ALL: begin
                        combined = &in_val;
                    end
                    default: begin
                        combined = 1'b0;
                    end
                endcase
            end

            // Inversion does not apply to no-operation: it stays off
            assign result = op_off ? 1'b0 :
                combined ^ output_inverted[g];
            assign delay_set = result ? on_set : off_set;
            // A change is due once the selected delay has run out
            assign flip = !op_off && result != work_bit[g] &&
                (delay_set == DELAY_RESET ||
                 (unit_pending && count + 1'b1 >= delay_set));

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    count <= DELAY_RESET;
                end else if (cycle_tick) begin
                    // Clearing on the flip leaves no credit from the old edge
                    if (result == work_bit[g] || op_off || flip) begin
                        count <= DELAY_RESET;
                    end else if (unit_pending) begin
                        count <= count + 1'b1;
                    end
                end
            end

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    work_bit[g] <= 1'b0;
                end else if (cycle_tick) begin
                    // Forcing off wins over a change still waiting
                    if (op_off) begin
                        work_bit[g] <= 1'b0;
                    end else if (flip) begin
                        work_bit[g] <= result;
                    end
                end
            end
        end
    endgenerate

endmodule

// *** verif/work_bit_chk.sv ***
// Purpose: Port-level checks for the work bit evaluator.
// Assumes: One clock domain, async active-high reset.
// Notes: Exact operation cases watched on bits 0, 1 and 4 only, to stay short; off-type and hold checks cover every bit.
`timescale 1ns/10ps
module work_bit_chk
    import work_bit_pkg::*;
#(
    parameter int N = NUM_WORK_BITS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration
    input wire logic cycle_tick,
    input wire logic [N*OP_W-1:0] op_type,
    input wire logic [N*NUM_INPUTS*CODE_W-1:0] input_select,
    input wire logic [N*NUM_INPUTS-1:0] input_inverted,
    input wire logic [N-1:0] output_inverted,
    input wire logic [N*DELAY_W-1:0] on_delay,
    input wire logic [N*DELAY_W-1:0] off_delay,
    // Result
    input wire logic [N-1:0] work_bit
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Bit 0 without inversions or delays, so the result is immediate
    wire plain0 = input_inverted[3:0] == 4'h0 && !output_inverted[0] &&
        ~|on_delay[13:0] && ~|off_delay[13:0];
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    tick_hold_a: assert property (!cycle_tick |=> $stable(work_bit))
        else $error("work bits moved without a cycle tick");
    for (genvar g = 0; g < N; g++) begin : g_bit
        op_off_a: assert property (cycle_tick &&
            (op_type[g*OP_W+:OP_W] == OP_NONE ||
            op_type[g*OP_W+:OP_W] > OP_ALL) |=> !work_bit[g])
            else $error("unused work bit not off");
    end
    ab_or_cd_a: assert property (cycle_tick && plain0 &&
        op_type[2:0] == OP_AB_OR_CD && input_select[23:0] == 24'h000041
        |=> work_bit[0]) else $error("type 1 result wrong");
    ac_and_bd_a: assert property (cycle_tick && plain0 &&
        op_type[2:0] == OP_AC_AND_BD && input_select[23:0] == 24'h040001
        |=> work_bit[0]) else $error("type 2 result wrong");
    any_const_a: assert property (cycle_tick && plain0 &&
        op_type[2:0] == OP_ANY && input_select[5:0] == 6'h01
        |=> work_bit[0]) else $error("type 3 result wrong");
    all_zero_a: assert property (cycle_tick && plain0 &&
        op_type[2:0] == OP_ALL && input_select[5:0] == 6'h00
        |=> !work_bit[0]) else $error("type 4 result wrong");
    reserved_a: assert property (cycle_tick && plain0 &&
        op_type[2:0] == OP_ANY && input_select[23:0] == 24'h000021
        |=> !work_bit[0]) else $error("reserved source not false");
    in_invert_a: assert property (cycle_tick && !output_inverted[1] &&
        op_type[5:3] == OP_ANY && input_select[47:24] == 24'h0 &&
        input_inverted[7:4] == 4'hf && ~|on_delay[27:14]
        |=> work_bit[1]) else $error("input inversion missing");
    out_invert_a: assert property (cycle_tick && output_inverted[4] &&
        op_type[14:12] == OP_ALL && input_select[119:96] == 24'h0 &&
        input_inverted[19:16] == 4'h0 && ~|on_delay[69:56]
        |=> work_bit[4]) else $error("output inversion missing");
endmodule

// *** verif/test_work_bit_logic_evaluator.sv ***
// Purpose: Self-checking bench for the work bit evaluator.
// Assumes: One second shortened to U clocks, so a minute unit is 60 U.
// Notes: Status inputs are all slices of one source vector src.
`timescale 1ns/10ps
bind work_bit_logic_evaluator work_bit_chk #(.N(N)) u_chk (.clk(clk),
    .rst(rst), .cycle_tick(cycle_tick), .op_type(op_type),
    .input_select(input_select), .input_inverted(input_inverted),
    .output_inverted(output_inverted), .on_delay(on_delay),
    .off_delay(off_delay), .work_bit(work_bit));
module test_work_bit_logic_evaluator;
    import work_bit_pkg::*;
    localparam int U = 10;
    typedef struct packed {logic [2:0] op; logic [15:0] truth;} row_t;
    // Truth tables indexed by {D,C,B,A}
    row_t rows [8] = '{'{3'h0, 16'h0000}, '{3'h1, 16'hf888},
        '{3'h2, 16'hfac8}, '{3'h3, 16'hfffe}, '{3'h4, 16'h8000},
        '{3'h5, 16'h0000}, '{3'h6, 16'h0000}, '{3'h7, 16'h0000}};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cycle_tick = 1'b0;
    logic [23:0] op_type = {8{OP_ANY}};
    logic [191:0] input_select = {8{18'h0, 6'h02}};
    logic [31:0] input_inverted = '0;
    logic [7:0] output_inverted = '0;
    logic [111:0] on_delay = '0;
    logic [111:0] off_delay = '0;
    logic delay_in_minutes = 1'b0;
    logic [46:0] src = 47'h2a5c_3e19_b6d4;
    logic [7:0] work_bit, exp, m;
    logic [3:0] cmb;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    int n;

    work_bit_logic_evaluator #(.CYCLES_PER_SEC(U)) u_dut (.clk(clk),
        .rst(rst), .cycle_tick(cycle_tick), .op_type(op_type),
        .input_select(input_select), .input_inverted(input_inverted),
        .output_inverted(output_inverted), .on_delay(on_delay),
        .off_delay(off_delay), .delay_in_minutes(delay_in_minutes),
        .event_in(src[8:3]), .alarm(src[12:9]), .heat_output(src[13]),
        .cool_output(src[14]), .input_error(src[15]),
        .heater_burnout_alarm(src[16]), .ssr_short_alarm(src[17]),
        .auto_manual(src[18]), .run_reset(src[19]), .hold(src[20]),
        .program_or_fixed_setpoint(src[21]), .autotune(src[22]),
        .ramp(src[23]), .standby(src[24]), .wait_state(src[25]),
        .time_signal(src[27:26]), .program_end(src[28]), .stage(src[29]),
        .program_number(src[32:30]), .segment_number(src[38:34]),
        .work_bit(work_bit));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    initial begin
        forever #50 clk = ~clk;
    end

    task automatic give_verdict();
        if (err_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        compares++;
        if (seen !== want) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h",
                $time, seen, want);
        end
    endtask

    // Cycles until bit 0 changes; bounded so a stuck timer cannot hang
    task automatic delay_of(input logic [5:0] code, input int lo, hi);
        input_select[5:0] = code;
        n = 0;
        @(negedge clk);
        while (work_bit[0] === ~code[0] && n < 2000) begin
            @(negedge clk);
            n++;
        end
        check({7'h0, n >= lo && n <= hi}, 8'h01);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(negedge clk);
        check(work_bit, 8'h00);
        rst = 1'b0;
        @(negedge clk);
        cycle_tick = 1'b1;
        @(negedge clk);
        check(work_bit, 8'hff);
        @(negedge clk);
        check(work_bit, 8'h00);
        // Odd bits reach their sources through inversion, upper bits invert
        foreach (rows[r]) for (int i = 0; i < 16; i++) begin
            for (int g = 0; g < 8; g++) begin
                cmb = 4'(i + g);
                op_type[g*3+:3] = rows[r].op;
                input_inverted[g*4+:4] = {4{g[0]}};
                output_inverted[g] = g >= 4;
                for (int k = 0; k < 4; k++)
                    input_select[(g*4+k)*6+:6] = {5'h0, cmb[k] ^ g[0]};
                exp[g] = rows[r].truth[cmb] ^
                    (g >= 4 && rows[r].op inside {[1:4]});
            end
            @(negedge clk);
            check(work_bit, exp);
        end
        op_type = {8{OP_ANY}};
        input_inverted = '0;
        output_inverted = '0;
        for (int p = 0; p < 2; p++) for (int c = 3; c < 39; c++) begin
            src = ~src;
            input_select = {8{18'h0, 6'(c)}};
            repeat (4) @(negedge clk);
            check(work_bit, {8{src[c] & (c != 33)}});
        end
        // Twisted ring: bit 0 takes bit 7 inverted, the rest shift up
        op_type = '0;
        @(negedge clk);
        op_type = {8{OP_ANY}};
        input_inverted = 32'h1;
        input_select = '0;
        for (int g = 0; g < 8; g++)
            input_select[g*24+:6] = 6'(39 + (g + 7) % 8);
        m = 8'h00;
        repeat (10) begin
            m = {m[6:0], ~m[7]};
            @(negedge clk);
            check(work_bit, m);
        end
        cycle_tick = 1'b0;
        repeat (3) @(negedge clk);
        check(work_bit, m);
        cycle_tick = 1'b1;
        op_type = {21'h0, OP_ANY};
        input_select = '0;
        input_inverted = '0;
        on_delay[13:0] = 14'h0003;
        off_delay[13:0] = 14'h0002;
        repeat (2) @(negedge clk);
        delay_of(6'h01, 2 * U, 3 * U + 2);
        delay_of(6'h00, U, 2 * U + 2);
        input_select[5:0] = 6'h01;
        repeat (15) @(negedge clk);
        input_select[5:0] = 6'h00;
        repeat (5) @(negedge clk);
        // A short true spell must not leave credit behind
        delay_of(6'h01, 2 * U, 3 * U + 2);
        delay_in_minutes = 1'b1;
        // Let a leftover second tick drain before timing minutes
        @(negedge clk);
        delay_of(6'h00, 60 * U, 120 * U + 2);
        give_verdict();
    end
endmodule
